// >>> tmc_pkg.sv
package tmc_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
  localparam logic [7:0] ADDR_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_CMP_A   = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B   = 8'h10;
  localparam logic [7:0] ADDR_FLAGS   = 8'h14;
  localparam logic [7:0] ADDR_MASK    = 8'h18;
  localparam logic [7:0] ADDR_SERVICE = 8'h1C;

  // Field positions in timer_control_a.
  localparam int ACT_A_POS = 6;
  localparam int ACT_B_POS = 4;
  localparam int WGM_LO_POS = 0;
  // Field positions in timer_control_b.
  localparam int FORCE_A_POS = 7;
  localparam int FORCE_B_POS = 6;
  localparam int WGM_HI_POS = 3;
  localparam int CS_POS = 0;
  // Flag and mask bit positions.
  localparam int OVF_POS = 0;
  localparam int MFA_POS = 1;
  localparam int MFB_POS = 2;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Waveform modes.
  localparam logic [2:0] WGM_NORMAL  = 3'h0;
  localparam logic [2:0] WGM_PC_MAX  = 3'h1;
  localparam logic [2:0] WGM_CTC     = 3'h2;
  localparam logic [2:0] WGM_FAST_MX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP  = 3'h5;
  localparam logic [2:0] WGM_FAST_CP = 3'h7;

  // Clock select codes.
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tmc_wreq_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] flags;
    logic [2:0] mask;
    logic out_a;
    logic out_b;
    logic dir_down;
    logic block;
    logic [9:0] pre;
    logic ext_q;
    logic aw_hold;
    logic w_hold;
    tmc_wreq_t wreq;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tmc_state_t;

endpackage : tmc_pkg

// >>> tmc_timer.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module tmc_timer
  import tmc_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pins and power gate.
  input  wire logic        timer_power_gate,
  input  wire logic        external_count_input,
  output logic             compare_output_a,
  output logic             compare_output_b,
  // Interrupt requests and service acknowledges.
  output logic             irq_overflow,
  output logic             irq_match_a,
  output logic             irq_match_b,
  input  wire logic        irq_ack_match_a,
  input  wire logic        irq_ack_match_b,
  input  wire logic        irq_ack_overflow
);

  tmc_state_t s_r;
  tmc_state_t s_nxt;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m != WGM_NORMAL) && (m != WGM_CTC);
  endfunction : is_pwm

  function automatic logic [1:0] apply_action(input logic [1:0] act,
                                              input logic cur);
    unique case (act)
      2'h0: apply_action = {1'b0, cur};
      2'h1: apply_action = {1'b0, ~cur};
      2'h2: apply_action = 2'b00;
      2'h3: apply_action = 2'b01;
    endcase
  endfunction : apply_action

  logic [2:0] wgm;
  logic       tick;
  logic       pre_hit;
  logic [7:0] top_val;
  logic       match_a;
  logic       match_b;
  logic       aw_ok;
  logic       w_ok;
  logic       do_wr;
  logic       do_rd;
  logic [7:0] wb;
  logic [7:0] rbyte;
  logic       rhit;
  logic       whit;
  logic       cnt_wr;

  assign wgm = {s_r.ctrl_b[WGM_HI_POS], s_r.ctrl_a[WGM_LO_POS +: 2]};
  assign top_val = (wgm == WGM_CTC || wgm == WGM_PC_CMP || wgm == WGM_FAST_CP)
                   ? s_r.cmp_a : CNT_MAX;

  always_comb
  begin
    unique case (s_r.ctrl_b[CS_POS +: 3])
      CS_DIV1:     pre_hit = 1'b1;
      CS_DIV8:     pre_hit = (s_r.pre[2:0] == 3'h7);
      CS_DIV64:    pre_hit = (s_r.pre[5:0] == 6'h3F);
      CS_DIV256:   pre_hit = (s_r.pre[7:0] == 8'hFF);
      CS_DIV1K:    pre_hit = (s_r.pre == 10'h3FF);
      CS_EXT_FALL: pre_hit = s_r.ext_q && !external_count_input;
      CS_EXT_RISE: pre_hit = !s_r.ext_q && external_count_input;
      default:     pre_hit = 1'b0;
    endcase
  end
  assign tick = pre_hit && !timer_power_gate;

  assign match_a = (s_r.count == s_r.cmp_a);
  assign match_b = (s_r.count == s_r.cmp_b);

  assign aw_ok = s_axi_awvalid && !s_r.aw_hold && !s_r.bvalid;
  assign w_ok  = s_axi_wvalid && !s_r.w_hold && !s_r.bvalid;
  assign s_axi_awready = aw_ok;
  assign s_axi_wready  = w_ok;
  assign do_wr = (s_r.aw_hold || aw_ok) && (s_r.w_hold || w_ok);
  assign s_axi_arready = !s_r.rvalid;
  assign do_rd = s_axi_arvalid && !s_r.rvalid;

  always_comb
  begin
    tmc_wreq_t  q;
    logic [1:0] oa;
    logic [1:0] ob;
    logic [2:0] ev;
    q = s_r.wreq;
    ev = 3'b000;
    oa = 2'b00;
    ob = 2'b00;
    s_nxt = s_r;
    whit = 1'b0;
    cnt_wr = 1'b0;
    if (aw_ok)
    begin
      s_nxt.wreq.addr = s_axi_awaddr;
      q.addr = s_axi_awaddr;
      s_nxt.aw_hold = 1'b1;
    end
    if (w_ok)
    begin
      s_nxt.wreq.data = s_axi_wdata;
      s_nxt.wreq.strb = s_axi_wstrb;
      q.data = s_axi_wdata;
      q.strb = s_axi_wstrb;
      s_nxt.w_hold = 1'b1;
    end
    wb = q.data[7:0];
    s_nxt.pre = s_r.pre + 10'd1;
    s_nxt.ext_q = external_count_input;
    // Counter unit.
    if (tick)
    begin
      s_nxt.block = 1'b0;
      unique case (wgm)
        WGM_PC_MAX, WGM_PC_CMP:
        begin
          if (s_r.count == top_val)
            s_nxt.dir_down = 1'b1;
          else if (s_r.count == CNT_BOTTOM)
            s_nxt.dir_down = 1'b0;
          if ((s_r.count == top_val) || (s_r.dir_down && s_r.count != CNT_BOTTOM))
            s_nxt.count = s_r.count - 8'd1;
          else
            s_nxt.count = s_r.count + 8'd1;
          if (s_r.count == CNT_BOTTOM && s_r.dir_down)
            ev[OVF_POS] = 1'b1;
        end
        WGM_CTC, WGM_FAST_MX, WGM_FAST_CP:
        begin
          s_nxt.dir_down = 1'b0;
          if (s_r.count == top_val)
            s_nxt.count = CNT_BOTTOM;
          else
            s_nxt.count = s_r.count + 8'd1;
          if (wgm == WGM_CTC ? (s_r.count == CNT_MAX) : (s_r.count == top_val))
            ev[OVF_POS] = 1'b1;
        end
        default:
        begin
          s_nxt.dir_down = 1'b0;
          s_nxt.count = s_r.count + 8'd1;
          if (s_r.count == CNT_MAX)
            ev[OVF_POS] = 1'b1;
        end
      endcase
      if (!s_r.block)
      begin
        if (match_a)
          ev[MFA_POS] = 1'b1;
        if (match_b)
          ev[MFB_POS] = 1'b1;
        // Waveform outputs.
        if (!is_pwm(wgm))
        begin
          if (match_a)
            oa = apply_action(s_r.ctrl_a[ACT_A_POS +: 2], s_r.out_a);
          else
            oa = {1'b0, s_r.out_a};
          if (match_b)
            ob = apply_action(s_r.ctrl_a[ACT_B_POS +: 2], s_r.out_b);
          else
            ob = {1'b0, s_r.out_b};
          s_nxt.out_a = oa[0];
          s_nxt.out_b = ob[0];
        end
        else
        begin
          if (match_a && s_r.ctrl_a[ACT_A_POS + 1])
            s_nxt.out_a = s_r.ctrl_a[ACT_A_POS] ^ (wgm == WGM_FAST_MX || wgm == WGM_FAST_CP
                          ? 1'b0 : !s_r.dir_down);
          if (match_b && s_r.ctrl_a[ACT_B_POS + 1])
            s_nxt.out_b = s_r.ctrl_a[ACT_B_POS] ^ (wgm == WGM_FAST_MX || wgm == WGM_FAST_CP
                          ? 1'b0 : !s_r.dir_down);
        end
      end
      if (is_pwm(wgm) && (wgm == WGM_FAST_MX || wgm == WGM_FAST_CP) &&
          s_r.count == top_val)
      begin
        if (s_r.ctrl_a[ACT_A_POS + 1])
          s_nxt.out_a = !s_r.ctrl_a[ACT_A_POS];
        if (s_r.ctrl_a[ACT_B_POS + 1])
          s_nxt.out_b = !s_r.ctrl_a[ACT_B_POS];
      end
      // Buffer update at top for fast PWM, at TOP for phase correct.
      if (is_pwm(wgm) && (s_r.count == top_val))
      begin
        s_nxt.cmp_a = s_r.buf_a;
        s_nxt.cmp_b = s_r.buf_b;
      end
    end
    // Interrupt service clears.
    if (irq_ack_overflow)
      s_nxt.flags[OVF_POS] = 1'b0;
    if (irq_ack_match_a)
      s_nxt.flags[MFA_POS] = 1'b0;
    if (irq_ack_match_b)
      s_nxt.flags[MFB_POS] = 1'b0;
    // Register writes.
    if (do_wr)
    begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      whit = q.strb[0];
      unique case (q.addr)
        ADDR_CTRL_A:
          if (whit)
            s_nxt.ctrl_a = wb;
        ADDR_CTRL_B:
          if (whit)
          begin
            s_nxt.ctrl_b = {2'b00, wb[5:0]};
            if (!is_pwm({wb[WGM_HI_POS], s_r.ctrl_a[WGM_LO_POS +: 2]}))
            begin
              oa = apply_action(s_r.ctrl_a[ACT_A_POS +: 2], s_r.out_a);
              ob = apply_action(s_r.ctrl_a[ACT_B_POS +: 2], s_r.out_b);
              if (wb[FORCE_A_POS])
                s_nxt.out_a = oa[0];
              if (wb[FORCE_B_POS])
                s_nxt.out_b = ob[0];
            end
          end
        ADDR_COUNT:
          if (whit)
          begin
            s_nxt.count = wb;
            s_nxt.block = 1'b1;
            cnt_wr = 1'b1;
          end
        ADDR_CMP_A:
          if (whit)
          begin
            if (is_pwm(wgm))
              s_nxt.buf_a = wb;
            else
              s_nxt.cmp_a = wb;
          end
        ADDR_CMP_B:
          if (whit)
          begin
            if (is_pwm(wgm))
              s_nxt.buf_b = wb;
            else
              s_nxt.cmp_b = wb;
          end
        ADDR_FLAGS:
          if (whit)
            s_nxt.flags = s_nxt.flags & ~wb[2:0];
        ADDR_MASK:
          if (whit)
            s_nxt.mask = wb[2:0];
        default:
          s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Hardware events win over a clear in the same cycle.
    s_nxt.flags = s_nxt.flags | ev;
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    // Register reads.
    rhit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL_A: rbyte = s_r.ctrl_a;
      ADDR_CTRL_B: rbyte = s_r.ctrl_b;
      ADDR_COUNT:  rbyte = s_r.count;
      ADDR_CMP_A:  rbyte = is_pwm(wgm) ? s_r.buf_a : s_r.cmp_a;
      ADDR_CMP_B:  rbyte = is_pwm(wgm) ? s_r.buf_b : s_r.cmp_b;
      ADDR_FLAGS:  rbyte = {5'h00, s_r.flags};
      ADDR_MASK:   rbyte = {5'h00, s_r.mask};
      ADDR_SERVICE: rbyte = {7'h00, s_r.out_b & s_r.out_a};
      default:
      begin
        rbyte = RESET_BYTE;
        rhit = 1'b0;
      end
    endcase
    if (do_rd)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = {24'h00_0000, rbyte};
      s_nxt.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp  = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata  = s_r.rdata;
  assign s_axi_rresp  = s_r.rresp;
  assign compare_output_a = s_r.out_a;
  assign compare_output_b = s_r.out_b;
  assign irq_overflow = s_r.flags[OVF_POS] & s_r.mask[OVF_POS];
  assign irq_match_a  = s_r.flags[MFA_POS] & s_r.mask[MFA_POS];
  assign irq_match_b  = s_r.flags[MFB_POS] & s_r.mask[MFB_POS];

  AST_STOPPED_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.ctrl_b[2:0] == CS_STOP) && !do_wr |=> s_r.count == $past(s_r.count))
    else $error("Counter moved while stopped.");
  AST_WRITE_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> s_r.count == $past(wb))
    else $error("Counter write lost to count.");
  AST_BLOCK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> s_r.block)
    else $error("Counter write did not block matches.");
  AST_FLAG_A_LATE: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && match_a && !s_r.block && !irq_ack_match_a && !do_wr |=> s_r.flags[MFA_POS])
    else $error("Match flag A not set on tick.");
  AST_BLOCKED_NO_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && s_r.block && !s_r.flags[MFB_POS] && !do_wr |=> !s_r.flags[MFB_POS])
    else $error("Blocked match set flag B.");
  AST_IRQ_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_r.mask[MFA_POS] |-> !irq_match_a)
    else $error("Masked request seen.");
  AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wgm == WGM_NORMAL && s_r.count == CNT_MAX && !do_wr
    |=> s_r.count == CNT_BOTTOM && s_r.flags[OVF_POS])
    else $error("Normal mode wrap wrong.");
  AST_NO_TICK_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_power_gate |-> !tick)
    else $error("Tick while gated.");

endmodule : tmc_timer

// >>> tmc_timer_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin miscompares++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tmc_timer_tb_top;
  import tmc_pkg::*;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        gate;
  logic        ext;
  logic        out_a;
  logic        out_b;
  logic        irq_ov;
  logic        irq_a;
  logic        irq_b;
  logic        ack_a;
  logic        ack_b;
  logic        ack_ov;
  int          miscompares;
  int          comparisons;
  logic [31:0] seed;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  v8;
  int          n;

  tmc_timer uut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (awaddr),
    .s_axi_awvalid        (awvalid),
    .s_axi_awready        (awready),
    .s_axi_wdata          (wdata),
    .s_axi_wstrb          (wstrb),
    .s_axi_wvalid         (wvalid),
    .s_axi_wready         (wready),
    .s_axi_bresp          (bresp),
    .s_axi_bvalid         (bvalid),
    .s_axi_bready         (bready),
    .s_axi_araddr         (araddr),
    .s_axi_arvalid        (arvalid),
    .s_axi_arready        (arready),
    .s_axi_rdata          (rdata),
    .s_axi_rresp          (rresp),
    .s_axi_rvalid         (rvalid),
    .s_axi_rready         (rready),
    .timer_power_gate     (gate),
    .external_count_input (ext),
    .compare_output_a     (out_a),
    .compare_output_b     (out_b),
    .irq_overflow         (irq_ov),
    .irq_match_a          (irq_a),
    .irq_match_b          (irq_b),
    .irq_ack_match_a      (ack_a),
    .irq_ack_match_b      (ack_b),
    .irq_ack_overflow     (ack_ov)
  );

  always #50 aclk = ~aclk;

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] dat, output logic [1:0] resp);
    logic aw_p;
    logic w_p;
    logic got;
    int   k;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h00_0000, dat};
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    k = 0;
    do
    begin
      @(negedge aclk);
      got = awready;
      if (wready)
        w_p = 1'b0;
      @(posedge aclk);
      if (got)
        aw_p = 1'b0;
      if (!aw_p)
        awvalid <= 1'b0;
      if (!w_p)
        wvalid <= 1'b0;
      k++;
    end
    while ((aw_p || w_p) && k < 50);
    k = 0;
    do
    begin
      @(negedge aclk);
      got = bvalid;
      resp = bresp;
      @(posedge aclk);
      k++;
    end
    while (!got && k < 50);
    bready <= 1'b0;
    `CHK("bvalid", 1'b1, got)
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic got;
    int   k;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    k = 0;
    do
    begin
      @(negedge aclk);
      got = arready;
      @(posedge aclk);
      k++;
    end
    while (!got && k < 50);
    arvalid <= 1'b0;
    k = 0;
    do
    begin
      @(negedge aclk);
      got = rvalid;
      dat = rdata;
      resp = rresp;
      @(posedge aclk);
      k++;
    end
    while (!got && k < 50);
    rready <= 1'b0;
    `CHK("rvalid", 1'b1, got)
  endtask : rd

  task automatic wok(input logic [7:0] a, input logic [7:0] dat);
    logic [1:0] resp;
    wr(a, dat, resp);
    `CHK("write resp", RESP_OKAY, resp)
  endtask : wok

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    logic [31:0] dat;
    logic [1:0]  resp;
    rd(a, dat, resp);
    `CHK("read resp", RESP_OKAY, resp)
    `CHK(nm, {24'h00_0000, ex}, dat)
  endtask : rchk

  task automatic run(input logic [2:0] cs, input int cyc);
    wok(ADDR_CTRL_B, {5'h00, cs});
    repeat (cyc) @(posedge aclk);
    wok(ADDR_CTRL_B, {5'h00, CS_STOP});
  endtask : run

  task automatic pulse_ack(input int which);
    if (which == 0)
      ack_ov <= 1'b1;
    if (which == 1)
      ack_a <= 1'b1;
    if (which == 2)
      ack_b <= 1'b1;
    @(posedge aclk);
    ack_ov <= 1'b0;
    ack_a  <= 1'b0;
    ack_b  <= 1'b0;
  endtask : pulse_ack

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    {gate, ext, ack_a, ack_b, ack_ov} = '0;
    miscompares = 0;
    comparisons = 0;
    seed = 32'h0001_6BF0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 32; a += 4)
      rchk("reset value", 8'(a), 8'h00);
    `CHK("out_a reset", 1'b0, out_a)
    rd(8'h20, d, r);
    `CHK("unmapped rresp", RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0000_0000, d)
    wr(8'h24, 8'h5A, r);
    `CHK("unmapped bresp", RESP_SLVERR, r)
    // Counter writes hold while no clock source is selected.
    for (int i = 0; i < 4; i++)
    begin
      d = xorshift();
      v8 = d[7:0];
      wok(ADDR_COUNT, v8);
      repeat (20) @(posedge aclk);
      rchk("count held", ADDR_COUNT, v8);
    end
    gate <= 1'b1;
    run(CS_DIV1, 20);
    rchk("count gated", ADDR_COUNT, v8);
    gate <= 1'b0;
    // Wrap through zero sets overflow and both matches against zero.
    wok(ADDR_COUNT, 8'hFD);
    run(CS_DIV1, 20);
    rchk("flags wrap", ADDR_FLAGS, 8'h07);
    wok(ADDR_MASK, 8'h01);
    `CHK("irq_ov", 1'b1, irq_ov)
    pulse_ack(0);
    @(posedge aclk);
    `CHK("irq_ov served", 1'b0, irq_ov)
    wok(ADDR_MASK, 8'h00);
    rchk("flags ack ovf", ADDR_FLAGS, 8'h06);
    wok(ADDR_FLAGS, 8'h02);
    rchk("flags w1c", ADDR_FLAGS, 8'h04);
    pulse_ack(2);
    rchk("flags ack b", ADDR_FLAGS, 8'h00);
    // Match on channel A with interrupt masking.
    d = xorshift();
    v8 = 8'h20 + {1'b0, d[6:0]};
    wok(ADDR_CMP_A, v8);
    wok(ADDR_CMP_B, v8 - 8'h10);
    wok(ADDR_COUNT, v8 - 8'h08);
    run(CS_DIV1, 20);
    rchk("flags match a", ADDR_FLAGS, 8'h02);
    `CHK("irq_a masked", 1'b0, irq_a)
    wok(ADDR_MASK, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK("irq_a", 1'b1, irq_a)
    `CHK("irq_b", 1'b0, irq_b)
    pulse_ack(1);
    repeat (2) @(posedge aclk);
    `CHK("irq_a served", 1'b0, irq_a)
    rchk("flags served", ADDR_FLAGS, 8'h00);
    wok(ADDR_MASK, 8'h00);
    // A counter write hides a match in the next tick only.
    d = xorshift();
    v8 = 8'h10 + {2'b00, d[5:0]};
    wok(ADDR_CMP_A, v8 + 8'h80);
    wok(ADDR_CMP_B, v8);
    for (int k = 0; k < 2; k++)
    begin
      wok(ADDR_FLAGS, 8'h07);
      wok(ADDR_COUNT, v8 - 8'(2 * k));
      run(CS_DIV1, 2);
      rchk("flags blocked", ADDR_FLAGS, (k == 1) ? 8'h04 : 8'h00);
    end
    // Force strobe with action codes 1 to 3, then a mode change.
    wok(ADDR_FLAGS, 8'h07);
    wok(ADDR_COUNT, 8'h33);
    for (int i = 0; i < 3; i++)
    begin
      wok(ADDR_CTRL_A, {2'(i + 1), 6'h00});
      wok(ADDR_CTRL_B, 8'hC0);
      repeat (2) @(posedge aclk);
      `CHK("out_a forced", (i != 1), out_a)
      `CHK("out_b idle", 1'b0, out_b)
    end
    rchk("flags forced", ADDR_FLAGS, 8'h00);
    rchk("count forced", ADDR_COUNT, 8'h33);
    wok(ADDR_CTRL_A, 8'hC3);
    repeat (2) @(posedge aclk);
    `CHK("out_a mode swap", 1'b1, out_a)
    // Clear on compare keeps the count at or below compare A.
    wok(ADDR_CTRL_A, 8'h02);
    wok(ADDR_CMP_A, 8'h10);
    rchk("cmp_a direct", ADDR_CMP_A, 8'h10);
    wok(ADDR_COUNT, 8'h00);
    run(CS_DIV1, 100);
    rd(ADDR_COUNT, d, r);
    `CHK("ctc bound", 1'b1, d[7:0] <= 8'h10)
    // Fast PWM buffers compare B; the active value changes only at TOP.
    wok(ADDR_CMP_B, 8'h80);
    wok(ADDR_CTRL_A, 8'h03);
    wok(ADDR_CMP_B, 8'h40);
    rchk("cmp_b buffer", ADDR_CMP_B, 8'h40);
    for (int k = 0; k < 3; k++)
    begin
      wok(ADDR_FLAGS, 8'h07);
      wok(ADDR_COUNT, (k == 1) ? 8'hFE : 8'h3E);
      run(CS_DIV1, 2);
      rchk("flags buf", ADDR_FLAGS, (k == 0) ? 8'h00 : ((k == 1) ? 8'h03 : 8'h04));
    end
    // External edges of either polarity are counted one for one.
    wok(ADDR_CTRL_A, 8'h00);
    n = 1 + int'(xorshift() % 9);
    for (int m = 0; m < 2; m++)
    begin
      wok(ADDR_COUNT, 8'h00);
      wok(ADDR_CTRL_B, {5'h00, (m == 0) ? CS_EXT_RISE : CS_EXT_FALL});
      repeat (n)
      begin
        ext <= 1'b1;
        repeat (4) @(posedge aclk);
        ext <= 1'b0;
        repeat (4) @(posedge aclk);
      end
      wok(ADDR_CTRL_B, 8'h00);
      rchk("ext count", ADDR_COUNT, 8'(n));
    end
    wok(ADDR_COUNT, 8'h00);
    run(CS_DIV8, 80);
    rd(ADDR_COUNT, d, r);
    `CHK("div8 count", 1'b1, d[7:0] >= 8'd10 && d[7:0] <= 8'd11)
    // A reset with the timer stopped clears the outputs and the counter again.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("out_a reset again", 1'b0, out_a)
    rchk("count reset", ADDR_COUNT, 8'h00);
    give_verdict();
  end

endmodule : tmc_timer_tb_top
